// >>> core/draw_regs_pkg.sv
// Package with register map, field layout, carriers and helpers for the draw register group.
// Overview of operation
// - Funnel count counts down once per vector pixel; host zeroes it for 3D vectors.
// - Pattern x offset stays 0 to 7 with bit 3 zero; blits may overwrite fields.
// - Blit funnel offset is a signed six-bit offset added to the funnel count.
// - Source words feed drawing; funnel count picks the style bit for styled vectors with replace or raster attribute.
// - Pick pending sets on pick event; only its clear or resets remove it.
// - Sync status bit follows the vertical sync signal directly.
// - Sync pending follows display flag; cleared by its clear or hard reset only.
// - Line pending sets when line count matches; clear, soft or hard reset clear it.
// - External pending shows the external interrupt pin level, also after hard reset.
// - Busy stays high while queue not empty, engine working or memory access open.
// - Reserved status bits read zero; host writes zeros there.
// - Status value is captured at read start and held for the whole read.
// - Line counter register reads the 12-bit count; writes do nothing.
// - Destination x holds the running signed x; ends at last vector pixel.
// - Blits load x from fill edges; depthless traps load max of fill and clip left.
// - Vector finish write sign-extends end x and y into accumulators zero and two.
// - Vector begin write loads x, accumulators five and six, y, and clears line select.
// - Bottom bound compares with destination y; rows beyond it are outside.
package draw_regs_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Byte offsets of the registers inside the aperture.
  localparam logic [15:0] OFF_SOURCE_WORD_0 = 16'h1c30;
  localparam logic [15:0] OFF_SOURCE_WORD_1 = 16'h1c34;
  localparam logic [15:0] OFF_SOURCE_WORD_2 = 16'h1c38;
  localparam logic [15:0] OFF_SOURCE_WORD_3 = 16'h1c3c;
  localparam logic [15:0] OFF_VECTOR_BEGIN_ALIAS = 16'h1c40;
  localparam logic [15:0] OFF_VECTOR_FINISH_ALIAS = 16'h1c44;
  localparam logic [15:0] OFF_SHIFTER_PATTERN_CONTROL = 16'h1c50;
  localparam logic [15:0] OFF_CLIP_BOTTOM = 16'h1c9c;
  localparam logic [15:0] OFF_DESTINATION_X = 16'h1cb0;
  localparam logic [15:0] OFF_ENGINE_STATE = 16'h1e14;
  localparam logic [15:0] OFF_RASTER_LINE_COUNTER = 16'h1e20;

  // Byte enables of a full dword access.
  localparam logic [3:0] BE_DWORD = 4'hf;

  // Status bit positions.
  localparam int ST_PICK = 2;
  localparam int ST_VSYNC_LEVEL = 3;
  localparam int ST_VSYNC_PEND = 4;
  localparam int ST_LINE_PEND = 5;
  localparam int ST_EXT_PEND = 6;
  localparam int ST_BUSY = 16;

  // Shifter control fields.
  localparam int SH_CNT_LSB = 0;
  localparam int SH_XOFF_LSB = 0;
  localparam int SH_YOFF_LSB = 4;
  localparam int SH_LEN_LSB = 16;

  // Reset values of held state.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0] RST_COUNT = 7'h00;

  // Engine side requests and state seen by the register group.
  typedef struct packed {
    logic vector_step;       // One vector pixel advanced.
    logic styled_vector;     // Current vector uses a line style.
    logic replace_attr;      // Replace attribute active.
    logic raster_op_attr;    // Raster attribute active.
    logic blit_shift_load;   // Engine rewrites shifter fields.
    logic [6:0] blit_funcnt; // New funnel count.
    logic [3:0] blit_xoff;   // New pattern x offset.
    logic [2:0] blit_yoff;   // New pattern y offset.
    logic destx_load_blit; // Load x from a fill edge.
    logic destx_load_trap; // Load x for a depthless trapezoid.
    logic scan_left;         // Blit scans right to left.
    logic [15:0] fill_left;  // Fill left edge.
    logic [15:0] fill_right; // Fill right edge.
    logic [15:0] clip_left;  // Clip left edge.
    logic destx_step; // Engine updates running x.
    logic [15:0] destx_value; // Updated running x.
    logic queue_empty;       // Command queue empty.
    logic engine_active;     // Drawing command in progress.
    logic mem_active;        // Memory access outstanding.
  } engine_ctl_t;

  // Values the register group drives toward the engine.
  typedef struct packed {
    logic [127:0] source_data;
    logic [6:0] funnel_count;
    logic [6:0] funnel_count_eff;
    logic [3:0] pattern_xoff;
    logic [2:0] pattern_yoff;
    logic [6:0] style_len;
    logic style_bit;
    logic [15:0] dest_x;
    logic [22:0] dest_y;
    logic [2:0] sel_line;
    logic [17:0] accumulator_zero;
    logic [17:0] accumulator_two;
    logic [17:0] accumulator_five;
    logic [17:0] accumulator_six;
    logic [23:0] clip_bottom_bound;
    logic outside_bottom;
  } coord_out_t;

  // Sign-extends a 16-bit coordinate to accumulator width.
  function automatic logic [17:0] sext18(input logic [15:0] v);
    sext18 = {{2{v[15]}}, v};
  endfunction

  // Sign-extends a 16-bit coordinate to destination y width.
  function automatic logic [22:0] sext23(input logic [15:0] v);
    sext23 = {{7{v[15]}}, v};
  endfunction

endpackage

// >>> core/sample_hold.sv
// Sample and hold register that freezes a read word for one bus access.
`timescale 1ns/10ps
module sample_hold #(
  parameter int WIDTH = 32
) (
  input wire logic clk,               // System clock.
  input wire logic resetn,            // Synchronous reset, active low.
  input wire logic capture,           // Take a new sample this cycle.
  input wire logic [WIDTH-1:0] d,     // Live value.
  output logic [WIDTH-1:0] q          // Held value.
);

  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  // The sample changes only on capture, so a read never sees a moving value.
  always_comb
  begin
    hold_next = hold_reg;
    if (capture)
    begin
      hold_next = d;
    end
  end

  // Registers the held value.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hold_reg <= '0;
    end
    else
    begin
      hold_reg <= hold_next;
    end
  end

  assign q = hold_reg;

endmodule

// >>> core/draw_engine_coord_status_regs.sv
// Drawing engine coordinate, shifter, source and status register group.
`timescale 1ns/10ps
module draw_engine_coord_status_regs (
  input wire logic clk,                              // System clock, 125 MHz.
  input wire logic resetn,                           // Hard reset, synchronous, active low.
  input wire logic soft_reset,                       // Soft reset level.
  input wire logic bus_req,                          // Access request, held until acknowledged.
  input wire logic bus_we,                           // High for write.
  input wire logic [15:0] bus_addr,                  // Byte address.
  input wire logic [3:0] bus_be,                     // Byte enables.
  input wire logic [31:0] bus_wdata,                 // Write data.
  output logic [31:0] bus_rdata,                     // Held read data.
  output logic bus_ack,                              // Access done, one cycle.
  input wire draw_regs_pkg::engine_ctl_t ctl,        // Engine requests and state.
  output draw_regs_pkg::coord_out_t coord,           // Values toward the engine.
  input wire logic pick_event,                       // Pick interrupt pulse.
  input wire logic pick_iclr,                        // Pick pending clear pulse.
  input wire logic vsync_level,                      // Vertical sync level.
  input wire logic vsync_event,                      // Display sync interrupt pulse.
  input wire logic vsync_iclr,                       // Sync pending clear pulse.
  input wire logic [11:0] line_count,                // Current vertical line.
  input wire logic [11:0] line_irq_count,            // Programmed interrupt line.
  input wire logic line_iclr,                        // Line pending clear pulse.
  input wire logic external_irq_pin_n                // External interrupt, active low.
);

  logic [127:0] source_reg;
  logic [127:0] source_next;
  logic [6:0] funcnt_reg;
  logic [6:0] funcnt_next;
  logic [3:0] xoff_reg;
  logic [3:0] xoff_next;
  logic [2:0] yoff_reg;
  logic [2:0] yoff_next;
  logic [6:0] len_reg;
  logic [6:0] len_next;
  logic style_reg;
  logic style_next;
  logic [15:0] destx_reg;
  logic [15:0] destx_next;
  logic [22:0] ydst_reg;
  logic [22:0] ydst_next;
  logic [2:0] sellin_reg;
  logic [2:0] sellin_next;
  logic [17:0] acc0_reg;
  logic [17:0] acc0_next;
  logic [17:0] acc2_reg;
  logic [17:0] acc2_next;
  logic [17:0] acc5_reg;
  logic [17:0] acc5_next;
  logic [17:0] acc6_reg;
  logic [17:0] acc6_next;
  logic [23:0] cybot_reg;
  logic [23:0] cybot_next;
  logic outside_reg;
  logic outside_next;
  logic pick_reg;
  logic pick_next;
  logic vsyncpen_reg;
  logic vsyncpen_next;
  logic linepen_reg;
  logic linepen_next;
  logic match_reg;
  logic match_next;
  logic ack_reg;
  logic ack_next;
  logic wr;
  logic rd;
  logic busy;
  logic line_match;
  logic [15:0] trap_x;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic [6:0] funoff_ext;

  // A request still standing in its acknowledge cycle is taken once; only dword writes land.
  assign wr = bus_req && !ack_reg && bus_we && (bus_be == draw_regs_pkg::BE_DWORD);
  assign rd = bus_req && !ack_reg && !bus_we;

  // Busy covers the queue, the engine and the memory controller.
  assign busy = !ctl.queue_empty || ctl.engine_active || ctl.mem_active;
  assign line_match = (line_count == line_irq_count);

  // Larger of fill left and clip left, both signed.
  assign trap_x = ($signed(ctl.fill_left) > $signed(ctl.clip_left)) ? ctl.fill_left
                                                                    : ctl.clip_left;

  // Funnel offset is the signed six-bit value in the low bits of the length field.
  assign funoff_ext = {len_reg[5], len_reg[5:0]};

  // Status word with reserved bits forced to zero.
  always_comb
  begin
    status_word = draw_regs_pkg::RST_WORD;
    status_word[draw_regs_pkg::ST_PICK] = pick_reg;
    status_word[draw_regs_pkg::ST_VSYNC_LEVEL] = vsync_level;
    status_word[draw_regs_pkg::ST_VSYNC_PEND] = vsyncpen_reg;
    status_word[draw_regs_pkg::ST_LINE_PEND] = linepen_reg;
    status_word[draw_regs_pkg::ST_EXT_PEND] = !external_irq_pin_n;
    status_word[draw_regs_pkg::ST_BUSY] = busy;
  end

  // Read decode; write-only and unmapped addresses read as zero.
  always_comb
  begin
    read_word = draw_regs_pkg::RST_WORD;
    if (bus_addr == draw_regs_pkg::OFF_ENGINE_STATE)
    begin
      read_word = status_word;
    end
    else if (bus_addr == draw_regs_pkg::OFF_RASTER_LINE_COUNTER)
    begin
      read_word = {20'h0_0000, line_count};
    end
  end

  // Captures the selected word when a read starts and holds it for the access.
  sample_hold #(
    .WIDTH(32)
  ) sample_hold_i (
    .clk(clk),
    .resetn(resetn),
    .capture(rd),
    .d(read_word),
    .q(bus_rdata)
  );

  // Interrupt pending flags; a set in the clear cycle wins.
  always_comb
  begin
    pick_next = pick_reg;
    vsyncpen_next = vsyncpen_reg;
    linepen_next = linepen_reg;
    match_next = line_match;
    if (pick_iclr || soft_reset)
    begin
      pick_next = 1'b0;
    end
    if (pick_event)
    begin
      pick_next = 1'b1;
    end
    if (vsync_iclr)
    begin
      vsyncpen_next = 1'b0;
    end
    if (vsync_event)
    begin
      vsyncpen_next = 1'b1;
    end
    if (line_iclr || soft_reset)
    begin
      linepen_next = 1'b0;
    end
    if (line_match && !match_reg)
    begin
      linepen_next = 1'b1;
    end
  end

  // Source words and shifter control.
  always_comb
  begin
    source_next = source_reg;
    funcnt_next = funcnt_reg;
    xoff_next = xoff_reg;
    yoff_next = yoff_reg;
    len_next = len_reg;
    if (wr && bus_addr == draw_regs_pkg::OFF_SOURCE_WORD_0)
    begin
      source_next[31:0] = bus_wdata;
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_SOURCE_WORD_1)
    begin
      source_next[63:32] = bus_wdata;
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_SOURCE_WORD_2)
    begin
      source_next[95:64] = bus_wdata;
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_SOURCE_WORD_3)
    begin
      source_next[127:96] = bus_wdata;
    end
    if (wr && bus_addr == draw_regs_pkg::OFF_SHIFTER_PATTERN_CONTROL)
    begin
      funcnt_next = bus_wdata[draw_regs_pkg::SH_CNT_LSB +: 7];
      xoff_next = {1'b0, bus_wdata[draw_regs_pkg::SH_XOFF_LSB +: 3]};
      yoff_next = bus_wdata[draw_regs_pkg::SH_YOFF_LSB +: 3];
      len_next = bus_wdata[draw_regs_pkg::SH_LEN_LSB +: 7];
    end
    else if (ctl.blit_shift_load)
    begin
      funcnt_next = ctl.blit_funcnt;
      xoff_next = {1'b0, ctl.blit_xoff[2:0]};
      yoff_next = ctl.blit_yoff;
    end
    else if (ctl.vector_step)
    begin
      // Counts down and wraps to the style length so the pattern repeats.
      if (funcnt_reg == draw_regs_pkg::RST_COUNT)
      begin
        funcnt_next = len_reg;
      end
      else
      begin
        funcnt_next = funcnt_reg - 7'h01;
      end
    end
    if (ctl.styled_vector && (ctl.replace_attr || ctl.raster_op_attr))
    begin
      style_next = source_next[funcnt_next];
    end
    else
    begin
      style_next = 1'b1;
    end
  end

  // Coordinates, accumulators and bottom clipping.
  always_comb
  begin
    destx_next = destx_reg;
    ydst_next = ydst_reg;
    sellin_next = sellin_reg;
    acc0_next = acc0_reg;
    acc2_next = acc2_reg;
    acc5_next = acc5_reg;
    acc6_next = acc6_reg;
    cybot_next = cybot_reg;
    if (wr && bus_addr == draw_regs_pkg::OFF_VECTOR_BEGIN_ALIAS)
    begin
      destx_next = bus_wdata[15:0];
      acc5_next = draw_regs_pkg::sext18(bus_wdata[15:0]);
      ydst_next = draw_regs_pkg::sext23(bus_wdata[31:16]);
      acc6_next = draw_regs_pkg::sext18(bus_wdata[31:16]);
      sellin_next = 3'h0;
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_VECTOR_FINISH_ALIAS)
    begin
      acc0_next = draw_regs_pkg::sext18(bus_wdata[15:0]);
      acc2_next = draw_regs_pkg::sext18(bus_wdata[31:16]);
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_CLIP_BOTTOM)
    begin
      cybot_next = bus_wdata[23:0];
    end
    else if (wr && bus_addr == draw_regs_pkg::OFF_DESTINATION_X)
    begin
      destx_next = bus_wdata[15:0];
    end
    else if (ctl.destx_load_blit)
    begin
      destx_next = ctl.scan_left ? ctl.fill_right : ctl.fill_left;
    end
    else if (ctl.destx_load_trap)
    begin
      destx_next = trap_x;
    end
    else if (ctl.destx_step)
    begin
      destx_next = ctl.destx_value;
    end
    // Negative rows are never beyond the bottom bound.
    outside_next = !ydst_next[22] && ({1'b0, ydst_next} > cybot_next);
  end

  // Acknowledge follows each taken request by one cycle.
  always_comb
  begin
    ack_next = bus_req && !ack_reg;
  end

  // Registers all state; soft reset clears only the pick and line pending flags.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      source_reg <= '0;
      funcnt_reg <= draw_regs_pkg::RST_COUNT;
      xoff_reg <= 4'h0;
      yoff_reg <= 3'h0;
      len_reg <= draw_regs_pkg::RST_COUNT;
      style_reg <= 1'b1;
      destx_reg <= 16'h0000;
      ydst_reg <= '0;
      sellin_reg <= 3'h0;
      acc0_reg <= '0;
      acc2_reg <= '0;
      acc5_reg <= '0;
      acc6_reg <= '0;
      cybot_reg <= '0;
      outside_reg <= 1'b0;
      pick_reg <= 1'b0;
      vsyncpen_reg <= 1'b0;
      linepen_reg <= 1'b0;
      match_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      source_reg <= source_next;
      funcnt_reg <= funcnt_next;
      xoff_reg <= xoff_next;
      yoff_reg <= yoff_next;
      len_reg <= len_next;
      style_reg <= style_next;
      destx_reg <= destx_next;
      ydst_reg <= ydst_next;
      sellin_reg <= sellin_next;
      acc0_reg <= acc0_next;
      acc2_reg <= acc2_next;
      acc5_reg <= acc5_next;
      acc6_reg <= acc6_next;
      cybot_reg <= cybot_next;
      outside_reg <= outside_next;
      pick_reg <= pick_next;
      vsyncpen_reg <= vsyncpen_next;
      linepen_reg <= linepen_next;
      match_reg <= match_next;
      ack_reg <= ack_next;
    end
  end

  // Drives the engine-facing carrier from registers.
  always_comb
  begin
    coord.source_data = source_reg;
    coord.funnel_count = funcnt_reg;
    coord.funnel_count_eff = funcnt_reg + funoff_ext;
    coord.pattern_xoff = xoff_reg;
    coord.pattern_yoff = yoff_reg;
    coord.style_len = len_reg;
    coord.style_bit = style_reg;
    coord.dest_x = destx_reg;
    coord.dest_y = ydst_reg;
    coord.sel_line = sellin_reg;
    coord.accumulator_zero = acc0_reg;
    coord.accumulator_two = acc2_reg;
    coord.accumulator_five = acc5_reg;
    coord.accumulator_six = acc6_reg;
    coord.clip_bottom_bound = cybot_reg;
    coord.outside_bottom = outside_reg;
  end

  assign bus_ack = ack_reg;

  // Checks on the register group behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_funcnt_down;
    ctl.vector_step && !ctl.blit_shift_load && !wr && funcnt_reg != 7'h00
      |=> funcnt_reg == $past(funcnt_reg) - 7'h01;
  endproperty
  a_funcnt_down: assert property (p_funcnt_down) else $error("funnel count missed a step");

  property p_xoff_range;
    ctl.blit_shift_load && !wr |=> xoff_reg[3] == 1'b0 && yoff_reg == $past(ctl.blit_yoff);
  endproperty
  a_xoff_range: assert property (p_xoff_range) else $error("pattern offset load wrong");

  property p_pick_set;
    pick_event |=> pick_reg ##0 status_word[2];
  endproperty
  a_pick_set: assert property (p_pick_set) else $error("pick pending not set");

  property p_pick_keep;
    pick_reg && !pick_iclr && !soft_reset |=> pick_reg;
  endproperty
  a_pick_keep: assert property (p_pick_keep) else $error("pick pending lost");

  property p_vsync_keep;
    vsyncpen_reg && !vsync_iclr |=> vsyncpen_reg;
  endproperty
  a_vsync_keep: assert property (p_vsync_keep) else $error("sync pending lost");

  property p_line_set;
    line_match && !match_reg |=> linepen_reg [*2] or (linepen_reg ##1 (line_iclr || soft_reset));
  endproperty
  a_line_set: assert property (p_line_set) else $error("line pending not set");

  property p_status_read;
    rd && bus_addr == 16'h1e14 |=> bus_ack && bus_rdata == $past(status_word);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read not held");

  property p_count_read;
    rd && bus_addr == 16'h1e20 |=> bus_rdata == {20'h0_0000, $past(line_count)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("line counter read wrong");

  property p_trap_x;
    ctl.destx_load_trap && !ctl.destx_load_blit && !wr |=> destx_reg == $past(trap_x);
  endproperty
  a_trap_x: assert property (p_trap_x) else $error("trapezoid x load wrong");

  property p_begin_alias;
    wr && bus_addr == 16'h1c40
      |=> acc5_reg == {{2{destx_reg[15]}}, destx_reg} && sellin_reg == 3'h0
          && acc6_reg[15:0] == ydst_reg[15:0] && destx_reg == $past(bus_wdata[15:0]);
  endproperty
  a_begin_alias: assert property (p_begin_alias) else $error("begin alias load wrong");

  property p_finish_alias;
    wr && bus_addr == 16'h1c44 |=> acc0_reg == {{2{$past(bus_wdata[15])}}, $past(bus_wdata[15:0])};
  endproperty
  a_finish_alias: assert property (p_finish_alias) else $error("finish alias load wrong");

  property p_busy;
    busy == status_word[16];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit mismatch");

endmodule

// >>> tb/host_bus_model.sv
// Host model that issues dword register accesses toward the draw register group.
`timescale 1ns/10ps
module host_bus_model (
  input wire logic clk, // System clock.
  output logic bus_req, // Access request.
  output logic bus_we, // Write select.
  output logic [15:0] bus_addr, // Byte address.
  output logic [3:0] bus_be, // Byte enables.
  output logic [31:0] bus_wdata, // Write data.
  input wire logic [31:0] bus_rdata, // Read data.
  input wire logic bus_ack // Access done.
);
  // The bus idles with no request pending.
  initial
  begin
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_addr = 16'h0000;
    bus_be = 4'h0;
    bus_wdata = 32'h0000_0000;
  end

  // One access; the request and its qualifiers stand until acknowledge is sampled high, at most five cycles.
  task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    bus_req <= 1'b1;
    bus_we <= we;
    bus_addr <= a;
    bus_be <= 4'hf;
    bus_wdata <= d;
    @(posedge clk);
    while (bus_ack !== 1'b1 && n < 4)
    begin
      n++;
      @(posedge clk);
    end
    q = (bus_ack === 1'b1) ? bus_rdata : 32'hdead_beef;
    bus_req <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
endmodule

// >>> tb/draw_engine_coord_status_regs_tb.sv
// Self-checking testbench for the draw register group.
`timescale 1ns/10ps
module draw_engine_coord_status_regs_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic soft_reset = 1'b0;
  logic bus_req, bus_we, bus_ack;
  logic [15:0] bus_addr;
  logic [3:0] bus_be;
  logic [31:0] bus_wdata, bus_rdata, q;
  draw_regs_pkg::engine_ctl_t ctl = '0;
  draw_regs_pkg::coord_out_t coord;
  logic pick_event = 1'b0, pick_iclr = 1'b0, vsync_level = 1'b0;
  logic vsync_event = 1'b0, vsync_iclr = 1'b0, line_iclr = 1'b0, ext_n = 1'b1;
  logic [11:0] line_count = 12'h000, line_irq_count = 12'h005;
  int failures = 0;
  int n_tests = 0;

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  draw_engine_coord_status_regs draw_engine_coord_status_regs_i (.clk(clk), .resetn(resetn),
    .soft_reset(soft_reset), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .ctl(ctl), .coord(coord), .pick_event(pick_event), .pick_iclr(pick_iclr),
    .vsync_level(vsync_level), .vsync_event(vsync_event), .vsync_iclr(vsync_iclr),
    .line_count(line_count), .line_irq_count(line_irq_count), .line_iclr(line_iclr),
    .external_irq_pin_n(ext_n));

  host_bus_model host_bus_model_i (.clk(clk), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));

  // Compares two words and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads the status word and compares it.
  task automatic st(input logic [31:0] exp);
    host_bus_model_i.xfer(1'b0, draw_regs_pkg::OFF_ENGINE_STATE, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Writes one register; a write that is never acknowledged counts as a mismatch.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host_bus_model_i.xfer(1'b1, a, d, q);
    if (q === 32'hdead_beef)
    begin
      chk(q, 32'h0000_0000);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Status after reset, then the read-only line counter.
  task automatic test_reset();
    st(32'h0000_0000);
    line_count <= 12'h123;
    host_bus_model_i.xfer(1'b0, draw_regs_pkg::OFF_RASTER_LINE_COUNTER, 32'h0, q);
    chk(q, 32'h0000_0123);
    wr(draw_regs_pkg::OFF_RASTER_LINE_COUNTER, 32'h0000_0fff);
    host_bus_model_i.xfer(1'b0, draw_regs_pkg::OFF_RASTER_LINE_COUNTER, 32'h0, q);
    chk(q, 32'h0000_0123);
    line_count <= 12'h000;
    $display("test_reset done");
  endtask

  // Pending flags set, survive or fall under soft reset, and clear by pulses.
  task automatic test_flags();
    @(posedge clk);
    pick_event <= 1'b1;
    vsync_event <= 1'b1;
    line_count <= 12'h005;
    vsync_level <= 1'b1;
    ext_n <= 1'b0;
    ctl.mem_active <= 1'b1;
    @(posedge clk);
    pick_event <= 1'b0;
    vsync_event <= 1'b0;
    st(32'h0001_007c);
    soft_reset <= 1'b1;
    vsync_level <= 1'b0;
    ext_n <= 1'b1;
    ctl.mem_active <= 1'b0;
    @(posedge clk);
    soft_reset <= 1'b0;
    line_count <= 12'h000;
    st(32'h0000_0010);
    pick_event <= 1'b1;
    line_count <= 12'h005;
    @(posedge clk);
    pick_event <= 1'b0;
    st(32'h0000_0034);
    pick_iclr <= 1'b1;
    vsync_iclr <= 1'b1;
    line_iclr <= 1'b1;
    @(posedge clk);
    pick_iclr <= 1'b0;
    vsync_iclr <= 1'b0;
    line_iclr <= 1'b0;
    st(32'h0000_0000);
    $display("test_flags done");
  endtask

  // Read data stays as sampled while the live bit moves.
  task automatic test_hold();
    vsync_level <= 1'b1;
    st(32'h0000_0008);
    vsync_level <= 1'b0;
    repeat (3) @(posedge clk);
    chk(bus_rdata, 32'h0000_0008);
    $display("test_hold done");
  endtask

  // Alias writes load coordinates; bottom clip compares at its boundary.
  task automatic test_alias();
    wr(draw_regs_pkg::OFF_VECTOR_BEGIN_ALIAS, 32'h8001_1234);
    chk(32'(coord.dest_x), 32'h0000_1234);
    chk(32'(coord.accumulator_five), 32'h0000_1234);
    chk(32'(coord.accumulator_six), 32'h0003_8001);
    chk(32'(coord.dest_y), 32'h007f_8001);
    chk(32'(coord.sel_line), 32'h0000_0000);
    wr(draw_regs_pkg::OFF_VECTOR_FINISH_ALIAS, 32'h7fff_fff0);
    chk(32'(coord.accumulator_zero), 32'h0003_fff0);
    chk(32'(coord.accumulator_two), 32'h0000_7fff);
    wr(draw_regs_pkg::OFF_CLIP_BOTTOM, 32'h0000_0020);
    chk(32'(coord.clip_bottom_bound), 32'h0000_0020);
    chk(32'(coord.outside_bottom), 32'h0000_0000);
    wr(draw_regs_pkg::OFF_VECTOR_BEGIN_ALIAS, 32'h0021_0000);
    chk(32'(coord.outside_bottom), 32'h0000_0001);
    wr(draw_regs_pkg::OFF_VECTOR_BEGIN_ALIAS, 32'h0020_0000);
    chk(32'(coord.outside_bottom), 32'h0000_0000);
    $display("test_alias done");
  endtask

  // Styled vector steps count down and pick the style bit from the source.
  task automatic test_style();
    wr(draw_regs_pkg::OFF_SOURCE_WORD_0, 32'h1010_1010);
    chk(coord.source_data[31:0], 32'h1010_1010);
    wr(draw_regs_pkg::OFF_SHIFTER_PATTERN_CONTROL, 32'h0007_0005);
    chk(32'(coord.style_len), 32'h0000_0007);
    chk(32'(coord.pattern_xoff), 32'h0000_0005);
    chk(32'(coord.funnel_count_eff), 32'h0000_000c);
    ctl.styled_vector <= 1'b1;
    ctl.replace_attr <= 1'b1;
    ctl.vector_step <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(coord.funnel_count), 32'h0000_0004);
    chk(32'(coord.style_bit), 32'h0000_0001);
    ctl.vector_step <= 1'b0;
    @(posedge clk);
    chk(32'(coord.funnel_count), 32'h0000_0003);
    chk(32'(coord.style_bit), 32'h0000_0000);
    $display("test_style done");
  endtask

  // Engine loads of the shifter fields and of the running x coordinate.
  task automatic test_engine();
    ctl.blit_shift_load <= 1'b1;
    ctl.blit_funcnt <= 7'h11;
    ctl.blit_xoff <= 4'hf;
    ctl.blit_yoff <= 3'h6;
    ctl.destx_load_trap <= 1'b1;
    ctl.fill_left <= 16'hfff0;
    ctl.clip_left <= 16'h0008;
    @(posedge clk);
    ctl.blit_shift_load <= 1'b0;
    ctl.destx_load_trap <= 1'b0;
    ctl.destx_load_blit <= 1'b1;
    ctl.scan_left <= 1'b1;
    ctl.fill_right <= 16'h0100;
    @(posedge clk);
    ctl.destx_load_blit <= 1'b0;
    chk(32'(coord.pattern_xoff), 32'h0000_0007);
    chk(32'(coord.pattern_yoff), 32'h0000_0006);
    chk(32'(coord.funnel_count), 32'h0000_0011);
    chk(32'(coord.dest_x), 32'h0000_0008);
    @(posedge clk);
    chk(32'(coord.dest_x), 32'h0000_0100);
    $display("test_engine done");
  endtask

  // Main sequence.
  initial
  begin
    ctl.queue_empty <= 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    test_reset();
    test_flags();
    test_hold();
    test_alias();
    test_style();
    test_engine();
    tally_and_finish();
  end

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
